/* File: verilog/pmu_regs_consts.vh */
/*
  register offsets, field positions, reset values and voltage scale
  constants for the regulator control and interrupt register bank.
  assumes: included by bare name from the design files.
*/
`ifndef PMU_REGS_CONSTS_VH
`define PMU_REGS_CONSTS_VH

`define GEN_LDO_CTRL_ADDR   8'h08
`define LN_LDO_CTRL_ADDR    8'h09
`define INT_MASK_ADDR       8'h0c
`define INT_REQ_ADDR        8'h0d

`define LDO_EN_BIT          5
`define LDO_CODE_MSB        4
`define LDO_RSVD_MASK       8'h3f

`define GEN_LDO_CODE_RST    5'h08
`define GEN_LDO_EN_RST      1'b1
`define LN_LDO_CODE_RST     5'h14
`define LN_LDO_EN_RST       1'b0
`define INT_MASK_RST        8'h00
`define INT_REQ_RST         8'h00

`define GEN_LDO_BASE_MV     12'd1200
`define GEN_LDO_SAT_CODE    5'h15
`define LN_LDO_BASE_MV      12'd1300
`define LN_LDO_SAT_CODE     5'h14
`define LDO_STEP_MV         12'd100
`define LDO_MAX_MV          12'd3300

`endif

/* File: verilog/ldo_channel.v */
/*
  one linear regulator channel: code to millivolt target, enable
  combination with an optional pin, and output shunt control.
  assumes: code and enable come from registers in the same clock domain.
*/
`timescale 1ns/1ps
`include "pmu_regs_consts.vh"

module ldo_channel #(
  parameter [11:0] BASE_MV  = `GEN_LDO_BASE_MV,
  parameter [4:0]  SAT_CODE = `GEN_LDO_SAT_CODE,
  parameter        PIN_CTRL = 0
) (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire [4:0]  i_code,
  input  wire        i_en_bit,
  input  wire        i_en_pin,
  output reg         o_on,
  output reg  [11:0] o_target_mv,
  output reg         o_shunt
);

  wire on_now;
  wire [11:0] mv_now;

  // with pin control the bit forces on, else the pin decides
  assign on_now = PIN_CTRL ? (i_en_bit | i_en_pin) : i_en_bit;

  // saturate at the top code so stray codes never overshoot
  assign mv_now = (i_code >= SAT_CODE) ? `LDO_MAX_MV :
                  (BASE_MV + `LDO_STEP_MV * {7'h00, i_code});

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_on        <= 1'b0;
      o_target_mv <= 12'h000;
      o_shunt     <= 1'b1;
    end
    else
    begin
      o_on        <= on_now;
      o_target_mv <= mv_now;
      o_shunt     <= ~on_now;
    end
  end

endmodule // ldo_channel

/* File: verilog/irq_capture.v */
/*
  interrupt capture: request register, hidden pending buffer, mask
  gating and the open-drain active-low request line.
  assumes: source strobes are synchronous one-cycle or level events.
*/
`timescale 1ns/1ps
`include "pmu_regs_consts.vh"

module irq_capture #(
  parameter N = 8
) (
  input  wire         i_clk,
  input  wire         i_rst_n,
  input  wire [N-1:0] i_src,
  input  wire [N-1:0] i_mask,
  input  wire         i_read_clr,
  output reg  [N-1:0] o_req,
  output wire         o_irq_out,
  output wire         o_irq_oe_n
);

  reg  [N-1:0] pending_buffer;
  reg  [N-1:0] next_req;
  reg  [N-1:0] next_pend;
  wire         assert_now;

  always @*
  begin
    next_req  = o_req | i_src;
    next_pend = pending_buffer;
    if (i_read_clr)
    begin
      // events racing the clearing read are parked, not lost
      next_req  = {N{1'b0}};
      next_pend = pending_buffer | i_src;
    end
    else if (pending_buffer != {N{1'b0}})
    begin
      // line released by the read; reload so it falls again at once
      next_req  = o_req | i_src | pending_buffer;
      next_pend = {N{1'b0}};
    end
  end

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_req          <= `INT_REQ_RST;
      pending_buffer <= {N{1'b0}};
    end
    else
    begin
      o_req          <= next_req;
      pending_buffer <= next_pend;
    end
  end

  assign assert_now = |(o_req & i_mask);
  assign o_irq_out  = 1'b0;
  // open drain: enable low means pulling the line down
  assign o_irq_oe_n = ~assert_now;

endmodule // irq_capture

/* File: verilog/pmu_reg_bank.v */
/*
  register bank for the two linear regulators and the interrupt mask
  and request registers, reached by a simple synchronous register port
  behind the two-wire host interface.
  assumes: the serial engine presents one-cycle read and write strobes
  with an 8-bit register address; all inputs are synchronous to the clock.
*/
`timescale 1ns/1ps
`include "pmu_regs_consts.vh"

module pmu_reg_bank #(
  parameter N_SRC = 8
) (
  input  wire             I_REF_CLK,
  input  wire             I_RST_N,
  input  wire [7:0]       I_REG_ADDR,
  input  wire [7:0]       I_REG_WDATA,
  input  wire             I_REG_WR,
  input  wire             I_REG_RD,
  output reg  [7:0]       O_REG_RDATA,
  output reg              O_REG_ACK,
  input  wire [N_SRC-1:0] I_INT_SOURCE_N,
  output wire             O_IRQ_OUT_N,
  output wire             O_IRQ_OUT_N_OE_N,
  input  wire             I_LOW_NOISE_ENABLE_PIN,
  output wire             O_GENERAL_REGULATOR_ON,
  output wire [11:0]      O_GENERAL_REGULATOR_MV,
  output wire             O_GENERAL_REGULATOR_SHUNT,
  output wire             O_LOW_NOISE_REGULATOR_ON,
  output wire [11:0]      O_LOW_NOISE_REGULATOR_MV,
  output wire             O_LOW_NOISE_REGULATOR_SHUNT
);

  reg  [4:0]       gen_code;
  reg              gen_en;
  reg  [4:0]       ln_code;
  reg              ln_en;
  reg  [N_SRC-1:0] interrupt_mask_reg;
  wire [N_SRC-1:0] request_bits;
  wire             req_read;
  reg  [7:0]       next_rdata;

  function [7:0] ldo_view;
    input       en;
    input [4:0] code;
    begin
      ldo_view = {2'b00, en, code} & `LDO_RSVD_MASK;
    end
  endfunction

  assign req_read = I_REG_RD & (I_REG_ADDR == `INT_REQ_ADDR);

  always @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      gen_code           <= `GEN_LDO_CODE_RST;
      gen_en             <= `GEN_LDO_EN_RST;
      ln_code            <= `LN_LDO_CODE_RST;
      ln_en              <= `LN_LDO_EN_RST;
      interrupt_mask_reg <= `INT_MASK_RST;
    end
    else if (I_REG_WR)
    begin
      // regulator writes drop bits 7:6, mask keeps all 8; request register ignores writes
      case (I_REG_ADDR)
        `GEN_LDO_CTRL_ADDR:
        begin
          gen_code <= I_REG_WDATA[`LDO_CODE_MSB:0];
          gen_en   <= I_REG_WDATA[`LDO_EN_BIT];
        end
        `LN_LDO_CTRL_ADDR:
        begin
          ln_code <= I_REG_WDATA[`LDO_CODE_MSB:0];
          ln_en   <= I_REG_WDATA[`LDO_EN_BIT];
        end
        `INT_MASK_ADDR:
          interrupt_mask_reg <= I_REG_WDATA[N_SRC-1:0];
        default:
          interrupt_mask_reg <= interrupt_mask_reg;
      endcase
    end
  end

  always @*
  begin
    case (I_REG_ADDR)
      `GEN_LDO_CTRL_ADDR: next_rdata = ldo_view(gen_en, gen_code);
      `LN_LDO_CTRL_ADDR:  next_rdata = ldo_view(ln_en, ln_code);
      `INT_MASK_ADDR:     next_rdata = interrupt_mask_reg;
      `INT_REQ_ADDR:      next_rdata = request_bits;
      default:            next_rdata = 8'h00;
    endcase
  end

  // read data is captured on the strobe so the clear cannot corrupt it
  always @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      O_REG_RDATA <= 8'h00;
      O_REG_ACK   <= 1'b0;
    end
    else
    begin
      O_REG_ACK <= I_REG_RD | I_REG_WR;
      if (I_REG_RD)
        O_REG_RDATA <= next_rdata;
    end
  end

  irq_capture #(
    .N (N_SRC)
  ) u_irq (
    .i_clk      (I_REF_CLK),
    .i_rst_n    (I_RST_N),
    .i_src      (I_INT_SOURCE_N),
    .i_mask     (interrupt_mask_reg),
    .i_read_clr (req_read),
    .o_req      (request_bits),
    .o_irq_out  (O_IRQ_OUT_N),
    .o_irq_oe_n (O_IRQ_OUT_N_OE_N)
  );

  // code is written before enable by software, so no ordering logic here
  ldo_channel #(
    .BASE_MV  (`GEN_LDO_BASE_MV),
    .SAT_CODE (`GEN_LDO_SAT_CODE),
    .PIN_CTRL (0)
  ) u_gen (
    .i_clk       (I_REF_CLK),
    .i_rst_n     (I_RST_N),
    .i_code      (gen_code),
    .i_en_bit    (gen_en),
    .i_en_pin    (1'b0),
    .o_on        (O_GENERAL_REGULATOR_ON),
    .o_target_mv (O_GENERAL_REGULATOR_MV),
    .o_shunt     (O_GENERAL_REGULATOR_SHUNT)
  );

  ldo_channel #(
    .BASE_MV  (`LN_LDO_BASE_MV),
    .SAT_CODE (`LN_LDO_SAT_CODE),
    .PIN_CTRL (1)
  ) u_ln (
    .i_clk       (I_REF_CLK),
    .i_rst_n     (I_RST_N),
    .i_code      (ln_code),
    .i_en_bit    (ln_en),
    .i_en_pin    (I_LOW_NOISE_ENABLE_PIN),
    .o_on        (O_LOW_NOISE_REGULATOR_ON),
    .o_target_mv (O_LOW_NOISE_REGULATOR_MV),
    .o_shunt     (O_LOW_NOISE_REGULATOR_SHUNT)
  );

endmodule // pmu_reg_bank

/* File: test/pmu_reg_bank_sva.sv */
/* port checker for the regulator and interrupt register bank.
   assumes: bound onto pmu_reg_bank, single clock domain. */
`timescale 1ns/1ps
module pmu_reg_bank_sva (
  input wire       I_REF_CLK,
  input wire       I_RST_N,
  input wire [7:0] I_REG_ADDR,
  input wire       I_REG_WR,
  input wire       I_REG_RD,
  input wire [7:0] O_REG_RDATA,
  input wire       O_REG_ACK,
  input wire       O_IRQ_OUT_N,
  input wire       O_IRQ_OUT_N_OE_N,
  input wire       I_LOW_NOISE_ENABLE_PIN,
  input wire       O_GENERAL_REGULATOR_ON,
  input wire       O_GENERAL_REGULATOR_SHUNT,
  input wire       O_LOW_NOISE_REGULATOR_ON,
  input wire       O_LOW_NOISE_REGULATOR_SHUNT
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_strobe;
    I_REG_WR || I_REG_RD;
  endsequence
  sequence s_req_read;
    I_REG_RD && I_REG_ADDR == 8'h0d;
  endsequence
  a_ack_follows: assert property (s_strobe |=> O_REG_ACK)
    else $error("ack missing after strobe");
  a_ack_single: assert property (!(I_REG_WR || I_REG_RD) |=> !O_REG_ACK)
    else $error("ack without strobe");
  a_rdata_holds: assert property (!I_REG_RD |=> $stable(O_REG_RDATA))
    else $error("read data moved without read");
  a_read_clears: assert property (s_req_read |=> O_IRQ_OUT_N_OE_N)
    else $error("request line held through clearing read");
  a_line_low: assert property (O_IRQ_OUT_N == 1'b0)
    else $error("open-drain drive value not low");
  a_gen_shunt: assert property (O_GENERAL_REGULATOR_SHUNT == !O_GENERAL_REGULATOR_ON)
    else $error("general shunt disagrees with on");
  a_ln_shunt: assert property (O_LOW_NOISE_REGULATOR_SHUNT == !O_LOW_NOISE_REGULATOR_ON)
    else $error("low-noise shunt disagrees with on");
  a_pin_enables: assert property (I_LOW_NOISE_ENABLE_PIN |=> O_LOW_NOISE_REGULATOR_ON)
    else $error("pin high but low-noise regulator off");
endmodule // pmu_reg_bank_sva
bind pmu_reg_bank pmu_reg_bank_sva chk_i (.*);

/* File: test/reg_host.sv */
/* host model driving the register strobe port.
   assumes: one-cycle strobes, ack one cycle later. */
`timescale 1ns/1ps
module reg_host (
  input  wire       i_clk,
  input  wire       i_ack,
  input  wire [7:0] i_rdata,
  output reg  [7:0] o_addr,
  output reg  [7:0] o_wdata,
  output reg        o_wr,
  output reg        o_rd
);
  initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0;
  // idle bus shows inverted last values so stale data cannot pass as live
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    begin
      @(negedge i_clk);
      {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
      @(negedge i_clk);
      {o_wr, o_rd, o_addr, o_wdata} = {2'b00, ~a, ~d};
      q = i_ack ? i_rdata : 8'hxx;
      @(negedge i_clk);
    end
  endtask
  task set_ldo(input logic [7:0] a, input logic [4:0] c, input logic en);
    logic [7:0] q;
    begin
      xfer(1'b1, a, {3'b000, c}, q);
      xfer(1'b1, a, {2'b00, en, c}, q);
    end
  endtask
endmodule // reg_host

/* File: test/tb_pmu_reg_bank.sv */
/* self-checking bench for the register bank.
   assumes: reg_host drives the port, sources and pin driven here. */
`timescale 1ns/1ps
module tb_pmu_reg_bank;
  logic       ref_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic       pin     = 1'b0;
  logic [7:0] src     = 8'h00;
  logic [7:0] q;
  wire  [7:0] addr, wdata, rdata;
  wire        wr, rd, ack, irq_n, oe_n, g_on, g_sh, n_on, n_sh;
  wire [11:0] g_mv, n_mv;
  int         error_cnt = 0;
  int         cmp_count = 0;
  localparam logic [4:0] CODES [6] = '{5'h00, 5'h08, 5'h13, 5'h14, 5'h15, 5'h1f};
  always #5 ref_clk = ~ref_clk;
  reg_host host (.i_clk(ref_clk), .i_ack(ack), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  pmu_reg_bank dut (.I_REF_CLK(ref_clk), .I_RST_N(rst_n), .I_REG_ADDR(addr),
    .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
    .O_REG_ACK(ack), .I_INT_SOURCE_N(src), .O_IRQ_OUT_N(irq_n), .O_IRQ_OUT_N_OE_N(oe_n),
    .I_LOW_NOISE_ENABLE_PIN(pin), .O_GENERAL_REGULATOR_ON(g_on),
    .O_GENERAL_REGULATOR_MV(g_mv), .O_GENERAL_REGULATOR_SHUNT(g_sh),
    .O_LOW_NOISE_REGULATOR_ON(n_on), .O_LOW_NOISE_REGULATOR_MV(n_mv),
    .O_LOW_NOISE_REGULATOR_SHUNT(n_sh));
  function automatic logic [11:0] mvf(input int b, input int c);
    return 12'((b + 100 * c > 3300) ? 3300 : b + 100 * c);
  endfunction
  task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    begin
      cmp_count++;
      if (g !== e)
      begin
        error_cnt++;
        $display("mismatch %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] e);
    begin
      host.xfer(1'b0, a, 8'h00, q);
      chk("rdata", e, q);
    end
  endtask
  // two edges cover the write-to-output latency
  task ldo_chk(input logic on_e, input logic [11:0] mv_e, input logic ln);
    begin
      repeat (2) @(negedge ref_clk);
      chk("on", on_e, ln ? n_on : g_on);
      chk("shunt", !on_e, ln ? n_sh : g_sh);
      chk("mv", mv_e, ln ? n_mv : g_mv);
    end
  endtask
  task t_reset;
    begin
      rdchk(8'h08, 8'h28);
      rdchk(8'h09, 8'h14);
      rdchk(8'h0c, 8'h00);
      rdchk(8'h0d, 8'h00);
      ldo_chk(1'b1, 12'd2000, 1'b0);
      ldo_chk(1'b0, 12'd3300, 1'b1);
      $display("test reset done");
    end
  endtask
  task t_codes;
    begin
      for (int i = 0; i < 6; i++)
      begin
        host.set_ldo(8'h08, CODES[i], 1'b1);
        ldo_chk(1'b1, mvf(1200, CODES[i]), 1'b0);
        host.set_ldo(8'h09, CODES[i], 1'b1);
        ldo_chk(1'b1, mvf(1300, CODES[i]), 1'b1);
      end
      host.xfer(1'b1, 8'h08, 8'hc0, q);
      rdchk(8'h08, 8'h00);
      ldo_chk(1'b0, 12'd1200, 1'b0);
      host.xfer(1'b1, 8'h0d, 8'hff, q);
      rdchk(8'h0d, 8'h00);
      rdchk(8'h20, 8'h00);
      $display("test codes done");
    end
  endtask
  task t_pin;
    begin
      host.set_ldo(8'h09, 5'h14, 1'b0);
      pin = 1'b1;
      ldo_chk(1'b1, 12'd3300, 1'b1);
      pin = 1'b0;
      ldo_chk(1'b0, 12'd3300, 1'b1);
      host.set_ldo(8'h09, 5'h14, 1'b1);
      ldo_chk(1'b1, 12'd3300, 1'b1);
      $display("test pin done");
    end
  endtask
  task t_irq;
    begin
      host.xfer(1'b1, 8'h0c, 8'h04, q);
      rdchk(8'h0c, 8'h04);
      src = 8'h24;
      @(negedge ref_clk) src = 8'h00;
      @(negedge ref_clk);
      chk("oe_n", 1'b0, oe_n);
      rdchk(8'h0d, 8'h24);
      chk("oe_n", 1'b1, oe_n);
      host.xfer(1'b1, 8'h0c, 8'h20, q);
      src = 8'h01;
      @(negedge ref_clk) src = 8'h00;
      @(negedge ref_clk);
      chk("oe_n", 1'b1, oe_n);
      host.xfer(1'b1, 8'h0c, 8'hff, q);
      src = 8'h01;
      @(negedge ref_clk) src = 8'h00;
      // the line is released for exactly the one cycle after the clearing read
      fork
        host.xfer(1'b0, 8'h0d, 8'h00, q);
        begin
          @(negedge ref_clk) src = 8'h02;
          @(negedge ref_clk) src = 8'h00;
          chk("oe_n", 1'b1, oe_n);
        end
      join
      chk("rdata", 8'h01, q);
      chk("oe_n", 1'b0, oe_n);
      rdchk(8'h0d, 8'h02);
      $display("test irq done");
    end
  endtask
  // reset again in mid-run: low-noise, mask and request registers and request line return to reset state
  task t_rerst;
    begin
      src = 8'h01;
      @(negedge ref_clk) src = 8'h00;
      rst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk("oe_n", 1'b1, oe_n);
      rst_n = 1'b1;
      rdchk(8'h09, 8'h14);
      rdchk(8'h0c, 8'h00);
      rdchk(8'h0d, 8'h00);
      $display("test rerst done");
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial
  begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    t_reset;
    t_codes;
    t_pin;
    t_irq;
    t_rerst;
    tally_and_finish;
  end
  // whole run needs well under a thousand cycles
  initial
  begin
    #100000;
    error_cnt++;
    tally_and_finish;
  end
endmodule // tb_pmu_reg_bank
